//--- include/spi_error_monitor_defines.svh
// constants for the serial-link fault monitor
// Function
// - three read-only fault flags, rest reserved
// - write transfers return 13-bit check pattern
// - last three diagnostic bits mirror fault flags
// - first fault latched, later faults ignored
// - fault with interrupt enabled raises request
// - error state accepts only fault-read command
// - fault-read reply takes two words, then clears
// - general target selected: reply code, clear
// - other target: filler reply, leave error
// - chip select low without system clock
// - burst word count differs from command
// - gap-tolerant mode watchdog timeout flags fault
// - framed mode nonzero count mismatch flags fault
// - wrong bit count in word flags fault
// - bit fault seen only at sequence end
// - no fault latched reads as zero
// - watchdog limit comes from configuration field
// - framed mode: first word command, rest data
`ifndef SPI_ERROR_MONITOR_DEFINES_SVH
`define SPI_ERROR_MONITOR_DEFINES_SVH

// ----------------------------------------------------------------
// register map and fields
// ----------------------------------------------------------------
`define FAULT_OFFSET 10'h1D3
`define FAULT_RESET 3'h0
`define BIT_MISS 2
`define BIT_FRAME 1
`define BIT_WORD 0
`define DIAG_PATTERN 13'h1555
`define CLEAR_CMD 16'hBA61
`define SEL_GENERAL 3'h4
`define FILLER_WORD 16'h0000
`define CMD_RD_BIT 15
`define CNT_HI 4

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SYS_CLK_NS 50
`define HB_HALF_NS 400
`define HB_HALF_CYC ((`HB_HALF_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS)
`define MISS_EDGES 4'h8
`define REPLY_WORDS 2'h2

`endif

//--- include/spi_error_monitor_pkg.sv
// types shared by the serial-link fault monitor
package spi_error_monitor_pkg;
  typedef enum logic [1:0] {st_idle, st_data, st_tail, st_err} proto_state_t;
endpackage

//--- verilog/spi_error_monitor.sv
// serial-link fault monitor: frame checks, fault latch, diagnostic reply
`timescale 1ns/1ps
`default_nettype none
`include "spi_error_monitor_defines.svh"

module spi_error_monitor #(
  parameter int WD_W = 12
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic sck,
  input wire logic csb_n,
  input wire logic mosi,
  input wire logic mode_b,
  input wire logic irq_en,
  input wire logic [2:0] target_sel,
  input wire logic [WD_W-1:0] wd_limit,
  output logic miso,
  output logic irq,
  output spi_error_monitor_pkg::proto_state_t proto_state,
  output logic [15:0] fault_flags
);
  import spi_error_monitor_pkg::*;

  // ----------------------------------------------------------------
  // link clock domain
  // ----------------------------------------------------------------
  logic [3:0] bit_cnt_q;
  logic [15:0] rx_sh_q;
  logic [15:0] rx_word_q;
  logic [15:0] tx_sh_q;
  logic word_tgl_q;
  logic mid_q;
  logic hb_s1_q;
  logic hb_s2_q;
  logic hb_s3_q;
  logic [3:0] miss_cnt_q;
  logic miss_tgl_q;
  logic [15:0] tx_q;
  logic hb_q;

  // frame end clears the per-frame counters, since sck stops outside frames
  wire frame_rst_n = rst_n & ~csb_n;
  wire hb_seen = hb_s2_q ^ hb_s3_q;
  wire word_last = (bit_cnt_q == 4'hF);

  always_ff @(posedge sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      bit_cnt_q <= 4'h0;
    end else begin
      bit_cnt_q <= bit_cnt_q + 4'h1;
    end
  end

  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      rx_sh_q <= 16'h0000;
      rx_word_q <= 16'h0000;
      word_tgl_q <= 1'b0;
      mid_q <= 1'b0;
    end else begin
      rx_sh_q <= {rx_sh_q[14:0], mosi};
      mid_q <= !word_last;
      if (word_last) begin
        rx_word_q <= {rx_sh_q[14:0], mosi};
        word_tgl_q <= ~word_tgl_q;
      end
    end
  end

  // tx_q is quasi-static: it only moves several sys cycles after a word end
  always_ff @(negedge sck or negedge rst_n) begin
    if (!rst_n) begin
      tx_sh_q <= {`DIAG_PATTERN, `FAULT_RESET};
    end else if (bit_cnt_q == 4'h0) begin
      tx_sh_q <= tx_q;
    end else begin
      tx_sh_q <= {tx_sh_q[14:0], 1'b0};
    end
  end

  assign miso = tx_sh_q[15];

  // system clock presence seen through a slow heartbeat
  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      hb_s1_q <= 1'b0;
      hb_s2_q <= 1'b0;
      hb_s3_q <= 1'b0;
      miss_tgl_q <= 1'b0;
    end else begin
      hb_s1_q <= hb_q;
      hb_s2_q <= hb_s1_q;
      hb_s3_q <= hb_s2_q;
      if (!hb_seen && miss_cnt_q == `MISS_EDGES - 4'h1) begin
        miss_tgl_q <= ~miss_tgl_q;
      end
    end
  end

  always_ff @(posedge sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      miss_cnt_q <= 4'h0;
    end else if (hb_seen) begin
      miss_cnt_q <= 4'h0;
    end else if (miss_cnt_q != `MISS_EDGES) begin
      miss_cnt_q <= miss_cnt_q + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // system clock domain: crossings
  // ----------------------------------------------------------------
  logic [3:0] hb_cnt_q;
  logic csb_s1_q;
  logic csb_s2_q;
  logic csb_s3_q;
  logic wt_s1_q;
  logic wt_s2_q;
  logic wt_s3_q;
  logic mid_s1_q;
  logic mid_s2_q;
  logic ms_s1_q;
  logic ms_s2_q;
  logic ms_s3_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hb_cnt_q <= 4'h0;
      hb_q <= 1'b0;
    end else if (hb_cnt_q == 4'(`HB_HALF_CYC - 1)) begin
      hb_cnt_q <= 4'h0;
      hb_q <= ~hb_q;
    end else begin
      hb_cnt_q <= hb_cnt_q + 4'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      csb_s1_q <= 1'b1;
      csb_s2_q <= 1'b1;
      csb_s3_q <= 1'b1;
      wt_s1_q <= 1'b0;
      wt_s2_q <= 1'b0;
      wt_s3_q <= 1'b0;
      mid_s1_q <= 1'b0;
      mid_s2_q <= 1'b0;
      ms_s1_q <= 1'b0;
      ms_s2_q <= 1'b0;
      ms_s3_q <= 1'b0;
    end else begin
      csb_s1_q <= csb_n;
      csb_s2_q <= csb_s1_q;
      csb_s3_q <= csb_s2_q;
      wt_s1_q <= word_tgl_q;
      wt_s2_q <= wt_s1_q;
      wt_s3_q <= wt_s2_q;
      mid_s1_q <= mid_q;
      mid_s2_q <= mid_s1_q;
      ms_s1_q <= miss_tgl_q;
      ms_s2_q <= ms_s1_q;
      ms_s3_q <= ms_s2_q;
    end
  end

  // ----------------------------------------------------------------
  // system clock domain: protocol and fault latch
  // ----------------------------------------------------------------
  proto_state_t state_q, state_d;
  logic [4:0] left_q, left_d;
  logic open_q, open_d;
  logic [1:0] rep_cnt_q, rep_cnt_d;
  logic rep_clr_q, rep_clr_d;
  logic [15:0] rep_word_q, rep_word_d;
  logic sel4_q, sel4_d;
  logic [2:0] fault_q, fault_d;
  logic [WD_W-1:0] wd_cnt_q, wd_cnt_d;
  logic irq_q;
  logic fault_clr;

  wire word_ev = wt_s2_q ^ wt_s3_q;
  wire csb_rise = csb_s2_q & ~csb_s3_q;
  wire miss_ev = ms_s2_q ^ ms_s3_q;
  wire is_clear_cmd = (rx_word_q == `CLEAR_CMD);
  wire [4:0] cmd_cnt = rx_word_q[`CNT_HI:0];
  wire in_data = (state_q == st_data);
  wire wd_hit = !mode_b && in_data && (wd_cnt_q == wd_limit) && !word_ev;
  wire short_b = mode_b && csb_rise && in_data && !open_q;
  wire excess_b = mode_b && word_ev && (state_q == st_tail);
  wire f_word = csb_rise && mid_s2_q;
  wire f_frame = wd_hit || short_b || excess_b;
  wire [2:0] new_fault = {miss_ev, f_frame, f_word};
  wire record = (fault_q == `FAULT_RESET) && (new_fault != 3'h0);
  wire [15:0] code_word = {13'h0000, fault_q};

  always_comb begin
    state_d = state_q;
    left_d = left_q;
    open_d = open_q;
    rep_cnt_d = rep_cnt_q;
    rep_clr_d = rep_clr_q;
    rep_word_d = rep_word_q;
    sel4_d = sel4_q;
    fault_clr = 1'b0;
    if (word_ev && rep_cnt_q != 2'h0) begin
      rep_cnt_d = rep_cnt_q - 2'h1;
      fault_clr = rep_clr_q && (rep_cnt_q == 2'h1);
    end
    case (state_q)
      st_idle: begin
        if (word_ev) begin
          if (is_clear_cmd && target_sel == `SEL_GENERAL) begin
            rep_cnt_d = `REPLY_WORDS;
            rep_clr_d = 1'b1;
            rep_word_d = code_word;
          end
          left_d = is_clear_cmd ? 5'(`REPLY_WORDS) : cmd_cnt;
          open_d = (cmd_cnt == 5'h00) && !is_clear_cmd;
          state_d = st_data;
        end
      end
      st_data: begin
        if (csb_rise && (mode_b || open_q)) begin
          state_d = st_idle;
        end else if (word_ev && !open_q) begin
          left_d = left_q - 5'h01;
          if (left_q == 5'h01) begin
            state_d = mode_b ? st_tail : st_idle;
          end
        end
      end
      st_tail: begin
        if (csb_rise || word_ev) begin
          state_d = st_idle;
        end
      end
      st_err: begin
        // every other word is dropped while the fault waits to be read
        if (word_ev && is_clear_cmd) begin
          rep_cnt_d = `REPLY_WORDS;
          rep_clr_d = sel4_q;
          rep_word_d = sel4_q ? code_word : `FILLER_WORD;
          left_d = 5'(`REPLY_WORDS);
          open_d = 1'b0;
          state_d = st_data;
        end
      end
      default: begin
        state_d = st_idle;
      end
    endcase
    if (record || (fault_clr && new_fault != 3'h0)) begin
      state_d = st_err;
      sel4_d = (target_sel == `SEL_GENERAL);
    end
  end

  // a fault arriving with the clear wins over it
  assign fault_d = fault_clr ? new_fault : (record ? new_fault : fault_q);
  assign wd_cnt_d = (!in_data || word_ev) ? '0 : (wd_cnt_q == wd_limit ? wd_cnt_q : wd_cnt_q + 1'b1);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= st_idle;
      left_q <= 5'h00;
      open_q <= 1'b0;
      rep_cnt_q <= 2'h0;
      rep_clr_q <= 1'b0;
      rep_word_q <= 16'h0000;
      sel4_q <= 1'b0;
      fault_q <= `FAULT_RESET;
      wd_cnt_q <= '0;
      irq_q <= 1'b0;
      tx_q <= {`DIAG_PATTERN, `FAULT_RESET};
    end else begin
      state_q <= state_d;
      left_q <= left_d;
      open_q <= open_d;
      rep_cnt_q <= rep_cnt_d;
      rep_clr_q <= rep_clr_d;
      rep_word_q <= rep_word_d;
      sel4_q <= sel4_d;
      fault_q <= fault_d;
      wd_cnt_q <= wd_cnt_d;
      irq_q <= (fault_d != 3'h0) && irq_en;
      tx_q <= (rep_cnt_d != 2'h0) ? rep_word_d : {`DIAG_PATTERN, fault_d};
    end
  end

  assign irq = irq_q;
  assign proto_state = state_q;
  assign fault_flags = {13'h0000, fault_q};

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_diag_pattern;
    @(posedge sys_clk) disable iff (!rst_n)
    (rep_cnt_q == 2'h0) |-> (tx_q[15:3] == `DIAG_PATTERN);
  endproperty
  a_diag_pattern: assert property (p_diag_pattern)
    else $error("diagnostic pattern wrong");

  property p_diag_mirror;
    @(posedge sys_clk) disable iff (!rst_n)
    (rep_cnt_q == 2'h0) |-> (tx_q[2:0] == fault_flags[2:0]);
  endproperty
  a_diag_mirror: assert property (p_diag_mirror)
    else $error("diagnostic flags do not mirror faults");

  property p_latch_hold;
    @(posedge sys_clk) disable iff (!rst_n)
    (fault_q != 3'h0 && !fault_clr) |=> (fault_q == $past(fault_q));
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("latched fault changed");

  property p_irq_follow;
    @(posedge sys_clk) disable iff (!rst_n)
    (fault_q != 3'h0 && $past(irq_en)) |-> irq;
  endproperty
  a_irq_follow: assert property (p_irq_follow)
    else $error("interrupt missing for latched fault");

  property p_err_reject;
    @(posedge sys_clk) disable iff (!rst_n)
    (state_q == st_err && word_ev && !is_clear_cmd) |=> (state_q == st_err && rep_cnt_q == 2'h0);
  endproperty
  a_err_reject: assert property (p_err_reject)
    else $error("error state left without clear command");

  property p_code_reply;
    @(posedge sys_clk) disable iff (!rst_n)
    (state_q == st_err && word_ev && is_clear_cmd && sel4_q) |=> (tx_q == {13'h0000, $past(fault_q)}) ##1 (fault_q != 3'h0);
  endproperty
  a_code_reply: assert property (p_code_reply)
    else $error("fault code reply wrong");

  property p_miss_flag;
    @(posedge sys_clk) disable iff (!rst_n)
    (miss_ev && fault_q == 3'h0) |=> fault_q[`BIT_MISS] ##1 (state_q == st_err);
  endproperty
  a_miss_flag: assert property (p_miss_flag)
    else $error("missing clock not flagged");

  property p_short_frame;
    @(posedge sys_clk) disable iff (!rst_n)
    (short_b && fault_q == 3'h0) |=> (fault_q[`BIT_FRAME] && state_q == st_err);
  endproperty
  a_short_frame: assert property (p_short_frame)
    else $error("short framed burst not flagged");

  property p_watchdog;
    @(posedge sys_clk) disable iff (!rst_n)
    (!mode_b && in_data && wd_cnt_q == wd_limit && !word_ev && fault_q == 3'h0) |=> fault_q[`BIT_FRAME];
  endproperty
  a_watchdog: assert property (p_watchdog)
    else $error("watchdog timeout not flagged");

  property p_word_flag;
    @(posedge sys_clk) disable iff (!rst_n)
    (csb_rise && mid_s2_q && fault_q == 3'h0) |=> fault_q[`BIT_WORD];
  endproperty
  a_word_flag: assert property (p_word_flag)
    else $error("bit count fault not flagged");

endmodule
`default_nettype wire

//--- bench/spi_host_model.sv
// host-side serial master model, mode 0, msb first
`timescale 1ns/1ps
`default_nettype none

module spi_host_model (
  output logic sck,
  output logic csb_n,
  output logic mosi,
  input wire logic miso
);
  // ----------------------------------------
  // link clock runs only inside frames
  // ----------------------------------------
  initial begin
    sck = 1'b0;
    csb_n = 1'b1;
    mosi = 1'b1;
  end

  // select on per frame, or per word to locate a bad word
  task automatic sel(input logic on);
    #80 csb_n = ~on;
    if (!on) begin
      #500;
    end
  endtask

  task automatic xfer(input logic [15:0] w, input int nbits, output logic [15:0] r);
    r = 16'h0000;
    for (int i = 0; i < nbits; i++) begin
      mosi = w[15-i];
      #80 sck = 1'b1;
      r = {r[14:0], miso};
      #80 sck = 1'b0;
    end
    // released data line must not keep the last bit
    mosi = ~mosi;
    #80;
  endtask
endmodule

`default_nettype wire

//--- bench/spi_error_monitor_tb.sv
// self-checking bench for the serial-link fault monitor
`timescale 1ns/1ps
`default_nettype none

module spi_error_monitor_tb;
  import spi_error_monitor_pkg::*;
  logic sys_clk, rst_n, mode_b, irq_en, clk_run, miso, irq, sck, csb_n, mosi;
  logic [2:0] target_sel;
  logic [11:0] wd_limit;
  proto_state_t proto_state;
  logic [15:0] fault_flags, rd;
  int n_mismatch, n_compared;
  localparam logic [15:0] WR1 = {1'b0, 10'h100, 5'h01};
  localparam logic [15:0] WR2 = {1'b0, 10'h100, 5'h02};
  localparam logic [15:0] WR0 = {1'b0, 10'h100, 5'h00};

  spi_error_monitor #(.WD_W(12)) uut (.sys_clk(sys_clk), .rst_n(rst_n), .sck(sck), .csb_n(csb_n),
    .mosi(mosi), .mode_b(mode_b), .irq_en(irq_en), .target_sel(target_sel), .wd_limit(wd_limit),
    .miso(miso), .irq(irq), .proto_state(proto_state), .fault_flags(fault_flags));
  spi_host_model host (.sck(sck), .csb_n(csb_n), .mosi(mosi), .miso(miso));

  // gated so a missing system clock can be staged
  always #25 if (clk_run) sys_clk = ~sys_clk;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic cfg(input logic m, input logic ie, input logic [2:0] ts);
    @(posedge sys_clk);
    mode_b <= m;
    irq_en <= ie;
    target_sel <= ts;
  endtask

  // command, then nw data words, the last one lastbits long
  task automatic frame(input logic [15:0] c, input int nw, input int lastbits);
    host.sel(1'b1);
    host.xfer(c, 16, rd);
    for (int i = 1; i <= nw; i++) begin
      host.xfer(16'h00A5, (i == nw) ? lastbits : 16, rd);
    end
    host.sel(1'b0);
  endtask

  task automatic wait_fault();
    int k;
    k = 0;
    while (fault_flags === 16'h0000 && k < 400) begin
      tick(1);
      k++;
    end
    if (k == 400) begin
      n_mismatch++;
      test_done();
    end
  endtask

  // reply lands in the second word after the command
  task automatic clear_read(input logic [15:0] exp);
    frame(16'hBA61, 2, 16);
    tick(8);
    chk("reply", exp, rd);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic s_reset();
    chk("flags", 16'h0000, fault_flags);
    chk("irq", 16'h0000, {15'h0000, irq});
    chk("state", 16'(st_idle), 16'(proto_state));
  endtask

  task automatic s_write_ok();
    cfg(1'b1, 1'b1, 3'h4);
    frame(WR1, 1, 16);
    tick(8);
    chk("diag", {13'h1555, 3'h0}, rd);
    chk("flags", 16'h0000, fault_flags);
  endtask

  task automatic s_bit_fault();
    frame(WR0, 1, 10);
    wait_fault();
    tick(2);
    chk("flags", 16'h0001, fault_flags);
    chk("irq", 16'h0001, {15'h0000, irq});
    chk("state", 16'(st_err), 16'(proto_state));
    // short burst while latched: refused and not recorded
    frame(WR2, 1, 16);
    tick(8);
    chk("diag", {13'h1555, 3'h1}, rd);
    chk("flags", 16'h0001, fault_flags);
    chk("state", 16'(st_err), 16'(proto_state));
    clear_read(16'h0001);
    chk("flags", 16'h0000, fault_flags);
    chk("irq", 16'h0000, {15'h0000, irq});
    chk("state", 16'(st_idle), 16'(proto_state));
  endtask

  task automatic s_count_fault();
    cfg(1'b1, 1'b0, 3'h0);
    frame(WR2, 1, 16);
    wait_fault();
    tick(2);
    chk("flags", 16'h0002, fault_flags);
    chk("irq", 16'h0000, {15'h0000, irq});
    clear_read(16'h0000);
    chk("flags", 16'h0002, fault_flags);
    chk("state", 16'(st_idle), 16'(proto_state));
    cfg(1'b1, 1'b1, 3'h4);
    clear_read(16'h0002);
    chk("flags", 16'h0000, fault_flags);
  endtask

  task automatic s_watchdog();
    cfg(1'b0, 1'b1, 3'h4);
    // a whole word plus its gap is about 53 cycles, so the limit must sit above it
    wd_limit <= 12'h050;
    frame(WR2, 1, 16);
    chk("flags", 16'h0000, fault_flags);
    wait_fault();
    chk("flags", 16'h0002, fault_flags);
    clear_read(16'h0002);
  endtask

  task automatic s_excess();
    cfg(1'b1, 1'b1, 3'h4);
    frame(WR1, 2, 16);
    wait_fault();
    tick(2);
    chk("flags", 16'h0002, fault_flags);
    chk("state", 16'(st_err), 16'(proto_state));
    clear_read(16'h0002);
    chk("flags", 16'h0000, fault_flags);
  endtask

  // gap-tolerant mode, select dropped after each word to locate a short one
  task automatic s_per_word();
    host.sel(1'b1);
    host.xfer(WR2, 16, rd);
    host.sel(1'b0);
    host.sel(1'b1);
    host.xfer(16'h00A5, 16, rd);
    host.sel(1'b0);
    chk("flags", 16'h0000, fault_flags);
    host.sel(1'b1);
    host.xfer(16'h00A5, 10, rd);
    host.sel(1'b0);
    wait_fault();
    tick(2);
    chk("flags", 16'h0001, fault_flags);
    clear_read(16'h0001);
    chk("flags", 16'h0000, fault_flags);
  endtask

  task automatic s_clk_missing();
    cfg(1'b1, 1'b1, 3'h4);
    clk_run = 1'b0;
    frame(WR1, 1, 16);
    clk_run = 1'b1;
    wait_fault();
    chk("flags", 16'h0004, fault_flags);
    clear_read(16'h0004);
  endtask

  initial begin
    sys_clk = 1'b0;
    clk_run = 1'b1;
    rst_n = 1'b0;
    mode_b = 1'b1;
    irq_en = 1'b1;
    target_sel = 3'h4;
    wd_limit = 12'hFFF;
    n_mismatch = 0;
    n_compared = 0;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    tick(3);
    s_reset();
    s_write_ok();
    s_bit_fault();
    s_count_fault();
    s_excess();
    s_watchdog();
    s_per_word();
    s_clk_missing();
    test_done();
  end
endmodule

`default_nettype wire
